/* File: fpc_regs.svh */
// Constants for the fuse PROM host controller
// What the fuse PROM and its programming sequence require
// R1: Device holds 256 four-bit words selected by an 8-bit address.
// R2: Blank bits read one; a programmed bit reads low.
// R3: Device enabled only with select low; outputs low when deselected.
// R4: Read data valid within 20 ns of a stable address.
// R5: Read data valid within 8.0 ns of select going low.
// R6: Host may use select as ninth address bit for 512 words.
// R7: Programmer sets programming address first, then raises program supply.
// R8: Program supply pulse starts at least 20 ns after address select.
// R9: With supply high, drive exactly one output to choose the bit.
// R10: Then draw a 40 mA select current pulse, nominally 100 us wide.
// R11: Verify: end pulse, release output, drop supply, normal address levels.
// R12: During verify enable the device with select low.
// R13: Sensed low means programmed; high means fail; at most eight attempts.
// R14: Each further bit repeats the whole sequence from word selection.
// R15: Program supply held at ground except while programming a bit.
// R16: Device read path is combinational with no internal state.
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
`define FPC_CLK_PERIOD_PS 25000
`define FPC_ADDR_ACCESS_TIME_PS 20000
`define FPC_SELECT_ACCESS_TIME_PS 8000
`define FPC_SETUP_TIME_PS 20000
`define FPC_CS_PULSE_US 100
`define FPC_SUPPLY_RISE_US 2
`define FPC_MAX_ATTEMPTS 8
`define FPC_ADDR_CYC ((`FPC_ADDR_ACCESS_TIME_PS + `FPC_CLK_PERIOD_PS - 1) / `FPC_CLK_PERIOD_PS)
`define FPC_SEL_CYC ((`FPC_SELECT_ACCESS_TIME_PS + `FPC_CLK_PERIOD_PS - 1) / `FPC_CLK_PERIOD_PS)
`define FPC_SETUP_CYC ((`FPC_SETUP_TIME_PS + `FPC_CLK_PERIOD_PS - 1) / `FPC_CLK_PERIOD_PS)
`define FPC_PULSE_CYC (`FPC_CS_PULSE_US * 1000000 / `FPC_CLK_PERIOD_PS)
`define FPC_RISE_CYC (`FPC_SUPPLY_RISE_US * 1000000 / `FPC_CLK_PERIOD_PS)
`endif

/* File: fpc_pkg.sv */
// Types for the fuse PROM host controller
package fpc_pkg;
    typedef enum logic [1:0] {FPC_CMD_NONE, FPC_CMD_READ, FPC_CMD_PROG} fpc_cmd_e;
    typedef struct packed {
        logic [8:0] addr;
        logic [1:0] bit_sel;
        fpc_cmd_e cmd;
    } fpc_req_s;
    typedef struct packed {
        logic [7:0] word_address;
        logic prog_levels;
        logic select_n_0;
        logic select_n_1;
        logic program_supply;
        logic [3:0] drive_en;
        logic cs_current;
    } fpc_pins_s;
    typedef struct packed {
        logic [3:0] data;
        logic ok;
        logic fail;
        logic [3:0] attempts;
    } fpc_rsp_s;
endpackage

/* File: fpc_timer.sv */
// Down-counting wait timer for the controller sequences
`timescale 1ns/1ps
module fpc_timer #(
    parameter int WIDTH = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] count_i,
    output logic done_o
);
    logic [WIDTH-1:0] cnt_reg;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
        end else if (load_i) begin
            cnt_reg <= count_i;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end
    // Done must not look at load_i: the caller derives load from done, which would close a loop
    assign done_o = (cnt_reg == '0);
endmodule

/* File: fpc_host.sv */
// Host controller that reads and programs a 256x4 fuse PROM pair
`timescale 1ns/1ps
`include "fpc_regs.svh"
module fpc_host #(
    parameter int PULSE_CYC = `FPC_PULSE_CYC,
    parameter int RISE_CYC = `FPC_RISE_CYC,
    parameter int MAX_ATTEMPTS = `FPC_MAX_ATTEMPTS
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire fpc_pkg::fpc_req_s req_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    output fpc_pkg::fpc_rsp_s rsp_o,
    output logic rsp_valid_o,
    input wire logic [3:0] data_out_i,
    output fpc_pkg::fpc_pins_s pins_o
);
    import fpc_pkg::*;

    localparam int TW = 16;
    typedef enum {ST_IDLE, ST_RD_WAIT, ST_RD_DONE, ST_P_ADDR, ST_P_SUPPLY, ST_P_DRIVE, ST_P_PULSE,
                  ST_V_DRIVE_OFF, ST_V_SUPPLY_OFF, ST_V_LEVELS, ST_V_SENSE} fpc_state_e;

    fpc_state_e state_reg;
    fpc_req_s req_reg;
    fpc_pins_s pins_reg;
    fpc_rsp_s rsp_reg;
    logic rsp_valid_reg;
    logic [3:0] attempt_reg;
    logic [3:0] d_meta_reg;
    logic [3:0] d_sync_reg;
    logic tmr_load;
    logic [TW-1:0] tmr_count;
    logic tmr_done;

    // Chip select doubles as the ninth address bit, so only one part is enabled
    function automatic logic [1:0] sel_n(input logic enable, input logic bank);
        sel_n = enable ? {!bank, bank} : 2'b11;
    endfunction

    function automatic logic [TW-1:0] cyc(input int n);
        cyc = (n < 1) ? TW'(1) : TW'(n);
    endfunction

    fpc_timer #(.WIDTH(TW)) u_timer (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .load_i(tmr_load),
        .count_i(tmr_count),
        .done_o(tmr_done)
    );

    // Outputs come from pins that are not on this clock
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            d_meta_reg <= 4'h0;
            d_sync_reg <= 4'h0;
        end else begin
            d_meta_reg <= data_out_i;
            d_sync_reg <= d_meta_reg;
        end
    end

    always_comb begin
        tmr_load = 1'b0;
        tmr_count = '0;
        case (state_reg)
            ST_IDLE: begin
                if (req_valid_i && req_i.cmd == FPC_CMD_READ) begin
                    tmr_load = 1'b1;
                    tmr_count = cyc(`FPC_ADDR_CYC + 2);
                end else if (req_valid_i && req_i.cmd == FPC_CMD_PROG) begin
                    tmr_load = 1'b1;
                    tmr_count = cyc(`FPC_SETUP_CYC);
                end
            end
            ST_P_ADDR, ST_P_SUPPLY, ST_P_PULSE, ST_V_DRIVE_OFF, ST_V_SUPPLY_OFF, ST_V_LEVELS: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_count = (state_reg == ST_P_SUPPLY) ? cyc(1) :
                                (state_reg == ST_P_ADDR || state_reg == ST_V_DRIVE_OFF) ? cyc(RISE_CYC) :
                                (state_reg == ST_P_DRIVE) ? cyc(PULSE_CYC - 1) :
                                (state_reg == ST_V_SUPPLY_OFF) ? cyc(`FPC_ADDR_CYC + `FPC_SEL_CYC + 2) :
                                cyc(`FPC_ADDR_CYC + `FPC_SEL_CYC + 2);
                end
            end
            ST_P_DRIVE: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    // A state lasts count plus one cycles, so one less gives the nominal width
                    tmr_count = cyc(PULSE_CYC - 1); // R10
                end
            end
            default: begin
                tmr_load = 1'b0;
                tmr_count = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            req_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    req_reg <= req_i;
                    if (req_valid_i && req_i.cmd == FPC_CMD_READ) begin
                        state_reg <= ST_RD_WAIT;
                    end else if (req_valid_i && req_i.cmd == FPC_CMD_PROG) begin
                        state_reg <= ST_P_ADDR;
                    end
                end
                ST_RD_WAIT: begin
                    if (tmr_done) begin
                        state_reg <= ST_RD_DONE;
                    end
                end
                ST_RD_DONE: state_reg <= ST_IDLE;
                ST_P_ADDR: if (tmr_done) state_reg <= ST_P_SUPPLY;
                ST_P_SUPPLY: if (tmr_done) state_reg <= ST_P_DRIVE;
                ST_P_DRIVE: if (tmr_done) state_reg <= ST_P_PULSE;
                ST_P_PULSE: if (tmr_done) state_reg <= ST_V_DRIVE_OFF;
                ST_V_DRIVE_OFF: if (tmr_done) state_reg <= ST_V_SUPPLY_OFF;
                ST_V_SUPPLY_OFF: if (tmr_done) state_reg <= ST_V_LEVELS;
                ST_V_LEVELS: if (tmr_done) state_reg <= ST_V_SENSE;
                ST_V_SENSE: begin
                    // Retry from word selection while the bit still reads high
                    if (d_sync_reg[req_reg.bit_sel] && attempt_reg < 4'(MAX_ATTEMPTS)) begin // R13 R14
                        state_reg <= ST_P_ADDR;
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Attempt counter; bounded so a dead fuse is never hammered past the limit
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            attempt_reg <= 4'h0;
        end else if (state_reg == ST_IDLE) begin
            attempt_reg <= 4'h0;
        end else if (state_reg == ST_P_ADDR && tmr_done) begin
            attempt_reg <= attempt_reg + 4'h1; // R13
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pins_reg <= '{word_address: 8'h00, prog_levels: 1'b0, select_n_0: 1'b1, select_n_1: 1'b1,
                          program_supply: 1'b0, drive_en: 4'h0, cs_current: 1'b0};
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    pins_reg.program_supply <= 1'b0; // R15
                    pins_reg.drive_en <= 4'h0;
                    pins_reg.cs_current <= 1'b0;
                    pins_reg.prog_levels <= 1'b0;
                    if (req_valid_i && req_i.cmd == FPC_CMD_READ) begin
                        pins_reg.word_address <= req_i.addr[7:0];
                        {pins_reg.select_n_1, pins_reg.select_n_0} <= sel_n(1'b1, req_i.addr[8]); // R6
                    end else if (req_valid_i && req_i.cmd == FPC_CMD_PROG) begin
                        pins_reg.word_address <= req_i.addr[7:0];
                        {pins_reg.select_n_1, pins_reg.select_n_0} <= 2'b11;
                    end else begin
                        {pins_reg.select_n_1, pins_reg.select_n_0} <= 2'b11;
                    end
                end
                ST_P_ADDR: begin
                    pins_reg.prog_levels <= 1'b1; // R7
                    {pins_reg.select_n_1, pins_reg.select_n_0} <= 2'b11;
                    if (tmr_done) pins_reg.program_supply <= 1'b1; // R8
                end
                ST_P_SUPPLY: if (tmr_done) pins_reg.drive_en <= 4'h1 << req_reg.bit_sel; // R9
                ST_P_DRIVE: if (tmr_done) pins_reg.cs_current <= 1'b1; // R10
                ST_P_PULSE: if (tmr_done) pins_reg.cs_current <= 1'b0; // R11
                ST_V_DRIVE_OFF: if (tmr_done) pins_reg.drive_en <= 4'h0; // R11
                ST_V_SUPPLY_OFF: begin
                    if (tmr_done) begin
                        pins_reg.program_supply <= 1'b0; // R11
                        pins_reg.prog_levels <= 1'b0;
                        {pins_reg.select_n_1, pins_reg.select_n_0} <= sel_n(1'b1, req_reg.addr[8]); // R12
                    end
                end
                default: begin
                    pins_reg.program_supply <= pins_reg.program_supply;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rsp_reg <= '0;
            rsp_valid_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= 1'b0;
            if (state_reg == ST_RD_DONE) begin
                rsp_reg <= '{data: d_sync_reg, ok: 1'b1, fail: 1'b0, attempts: 4'h0}; // R4 R5
                rsp_valid_reg <= 1'b1;
            end else if (state_reg == ST_V_SENSE &&
                         (!d_sync_reg[req_reg.bit_sel] || attempt_reg >= 4'(MAX_ATTEMPTS))) begin
                rsp_reg <= '{data: d_sync_reg, ok: !d_sync_reg[req_reg.bit_sel],
                             fail: d_sync_reg[req_reg.bit_sel], attempts: attempt_reg}; // R13
                rsp_valid_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            req_ready_o <= 1'b0;
        end else begin
            req_ready_o <= (state_reg == ST_IDLE) && !req_valid_i;
        end
    end

    assign rsp_o = rsp_reg;
    assign rsp_valid_o = rsp_valid_reg;
    assign pins_o = pins_reg;

    AST_ONE_BIT: assert property (@(posedge core_clk_i) disable iff (rst_i) // R9
        $countones(pins_reg.drive_en) <= 1) else $error("more than one output driven");
    AST_SUPPLY_BEFORE_DRIVE: assert property (@(posedge core_clk_i) disable iff (rst_i) // R7
        (pins_reg.drive_en != 4'h0) |-> (pins_reg.program_supply && pins_reg.prog_levels))
        else $error("output driven without program supply");
    AST_PULSE_NEEDS_DRIVE: assert property (@(posedge core_clk_i) disable iff (rst_i) // R10
        pins_reg.cs_current |-> (pins_reg.drive_en != 4'h0)) else $error("select pulse without drive");
    AST_SUPPLY_ONLY_PROG: assert property (@(posedge core_clk_i) disable iff (rst_i) // R15
        pins_reg.program_supply |-> pins_reg.prog_levels) else $error("supply high outside programming");
    AST_SETUP: assert property (@(posedge core_clk_i) disable iff (rst_i) // R8
        $rose(pins_reg.program_supply) |-> $past(pins_reg.prog_levels)) else $error("supply before address");
    AST_RELEASE_ORDER: assert property (@(posedge core_clk_i) disable iff (rst_i) // R11
        $fell(pins_reg.drive_en != 4'h0) |-> !pins_reg.cs_current && pins_reg.program_supply)
        else $error("drive released out of order");
    AST_ATTEMPTS: assert property (@(posedge core_clk_i) disable iff (rst_i) // R13
        attempt_reg <= 4'(MAX_ATTEMPTS)) else $error("too many attempts");
    AST_ONE_SELECT: assert property (@(posedge core_clk_i) disable iff (rst_i) // R6
        pins_reg.select_n_0 || pins_reg.select_n_1) else $error("both parts selected");
    sequence seq_supply_drop;
        $fell(pins_reg.program_supply);
    endsequence
    AST_VERIFY_ENABLE: assert property (@(posedge core_clk_i) disable iff (rst_i) // R12
        seq_supply_drop |-> !pins_reg.prog_levels && (pins_reg.select_n_0 != pins_reg.select_n_1))
        else $error("verify read not enabled");
endmodule

/* File: fpc_prom_model.sv */
// Behavioural model of two 256x4 fuse PROM parts sharing wired-OR outputs
`timescale 1ns/1ps
module fpc_prom_model #(
    parameter int PULSE_MIN = 10
) (
    input wire logic core_clk_i,
    input wire fpc_pkg::fpc_pins_s pins_i,
    input wire logic arm_i,
    input wire logic [3:0] refuse_i,
    output logic [3:0] data_out_o
);
    import fpc_pkg::*;
    logic [3:0] mem [2][256];
    logic [3:0] refuse_cnt = 4'h0;
    int pulse_len = 0;
    logic pend = 1'b0;
    logic [7:0] pend_addr = 8'h00;
    logic [3:0] pend_mask = 4'h0;
    initial begin
        foreach (mem[p, a]) mem[p][a] = 4'hf;
    end
    // Lines have pull-downs, so a deselected or programming-level part reads low
    always @* begin
        data_out_o = 4'h0;
        if (!pins_i.prog_levels && !pins_i.program_supply) begin
            if (!pins_i.select_n_0) data_out_o = data_out_o | mem[0][pins_i.word_address];
            if (!pins_i.select_n_1) data_out_o = data_out_o | mem[1][pins_i.word_address];
        end
    end
    // A fuse blows only after a full pulse under supply with one output driven
    always @(posedge core_clk_i) begin
        pulse_len <= pins_i.cs_current ? pulse_len + 1 : 0;
        if (arm_i) refuse_cnt <= refuse_i;
        if (!pins_i.cs_current && pulse_len >= PULSE_MIN && pins_i.program_supply && pins_i.prog_levels
            && $onehot(pins_i.drive_en)) begin
            if (refuse_cnt != 4'h0) begin
                refuse_cnt <= refuse_cnt - 4'h1;
            end else begin
                pend <= 1'b1;
                pend_addr <= pins_i.word_address;
                pend_mask <= pins_i.drive_en;
            end
        end
        // The blown bit shows up once the part is read back at normal levels
        if (pend && !pins_i.prog_levels && !pins_i.program_supply && (pins_i.select_n_0 != pins_i.select_n_1)) begin
            mem[pins_i.select_n_0][pend_addr] <= mem[pins_i.select_n_0][pend_addr] & ~pend_mask;
            pend <= 1'b0;
        end
    end
endmodule

/* File: testbench.sv */
// Self-checking bench for the fuse PROM host controller
`timescale 1ns/1ps
module testbench;
    import fpc_pkg::*;
    localparam int PULSE = 10;
    logic core_clk;
    logic rst;
    fpc_req_s req;
    logic req_valid;
    logic req_ready;
    fpc_rsp_s rsp;
    fpc_rsp_s got;
    logic rsp_valid;
    logic [3:0] data_out;
    fpc_pins_s pins;
    fpc_pins_s prev;
    fpc_pins_s p;
    logic arm;
    logic [3:0] refuse;
    logic [3:0] shadow [512];
    logic [31:0] seed = 32'h6080;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int cs_len = 0;

    fpc_host #(.PULSE_CYC(PULSE), .RISE_CYC(2), .MAX_ATTEMPTS(8)) u_dut (
        .core_clk_i(core_clk), .rst_i(rst), .req_i(req), .req_valid_i(req_valid), .req_ready_o(req_ready),
        .rsp_o(rsp), .rsp_valid_o(rsp_valid), .data_out_i(data_out), .pins_o(pins));
    fpc_prom_model #(.PULSE_MIN(PULSE)) u_prom (
        .core_clk_i(core_clk), .pins_i(pins), .arm_i(arm), .refuse_i(refuse), .data_out_o(data_out));

    always #12.5 core_clk = ~core_clk;

    task automatic end_sim;
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    function automatic logic [5:0] exp_prog(input logic [3:0] n, input logic blank);
        // A bit already blown senses low on the first pass; the limit caps passes at eight
        if (!blank) return {2'b10, 4'h1};
        return (n >= 4'h8) ? {2'b01, 4'h8} : {2'b10, n + 4'h1};
    endfunction

    // Pin watcher at the falling edge, where the registered pins have settled
    always @(negedge core_clk) begin
        p = pins;
        if (!rst) begin
            if (p.program_supply && !prev.program_supply) check({prev.prog_levels, prev.word_address}, {1'b1, p.word_address});
            if (p.drive_en != 4'h0) check({$onehot(p.drive_en), p.program_supply}, 2'b11);
            if (p.cs_current) check({p.drive_en != 4'h0, p.program_supply}, 2'b11);
            if (!p.cs_current && prev.cs_current) check(16'(cs_len), 16'(PULSE));
            if (p.drive_en == 4'h0 && prev.drive_en != 4'h0) check(prev.cs_current, 1'b0);
            if (!p.program_supply && prev.program_supply) check(prev.drive_en, 4'h0);
            if (p.program_supply) check(p.prog_levels, 1'b1);
            if (req_ready) check(p.program_supply, 1'b0);
            check(p.select_n_0 | p.select_n_1, 1'b1);
            cs_len = p.cs_current ? cs_len + 1 : 0;
        end
        prev = p;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            end_sim;
        end
    end

    task automatic do_req(input fpc_cmd_e cmd, input logic [8:0] addr, input logic [1:0] bsel);
        int n;
        n = 0;
        // Valid is raised only once idle is seen, so the request is taken at exactly one edge
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        check(req_ready, 1'b1);
        req = '{addr: addr, bit_sel: bsel, cmd: cmd};
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        check(rsp_valid, 1'b1);
        got = rsp;
    endtask

    task automatic do_read(input logic [8:0] addr);
        do_req(FPC_CMD_READ, addr, 2'h0);
        check({got.ok, got.data}, {1'b1, shadow[addr]});
    endtask

    // The model ignores the first n pulses, so a bit needs n+1 passes
    task automatic do_prog(input logic [8:0] addr, input logic [1:0] bsel, input logic [3:0] n);
        arm = 1'b1;
        refuse = n;
        @(negedge core_clk);
        arm = 1'b0;
        do_req(FPC_CMD_PROG, addr, bsel);
        check({got.ok, got.fail, got.attempts}, exp_prog(n, shadow[addr][bsel]));
        if (n < 4'h8) shadow[addr][bsel] = 1'b0;
        do_read(addr);
    endtask

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        req = '0;
        req_valid = 1'b0;
        arm = 1'b0;
        refuse = 4'h0;
        foreach (shadow[i]) shadow[i] = 4'hf;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        do_read(9'h000);
        do_read(9'h1ff);
        do_prog(9'h000, 2'h0, 4'h0);
        do_prog(9'h1ff, 2'h3, 4'h7);
        do_prog(9'h100, 2'h1, 4'h8);
        do_prog(9'h0ff, 2'h2, 4'h1);
        for (int i = 0; i < 24; i++) begin
            seed = xorshift(seed);
            do_prog(seed[8:0], seed[10:9], {2'h0, 2'(seed[13:12] % 3)});
            do_read(seed[30:22]);
        end
        end_sim;
    end
endmodule
